// >>> rtl/pieb_bank.v
// peripheral interrupt enable bank, groups four to nine
//
// Operation
// - group4: lc1,wg1,osc1,-,cc1,t2,t1g,t1
// - group5: i2c2 tx/rx, dma2 events, cmp2, pin1
// - group6: t3g,t3,ser2 gen/fe/tx/rx,i2c2 err/gen
// - group7: bits 7,6,2 absent; pin2,lc2,wg2,cc2,t4
// - group8: only t5 gate, t5 at 7,6
// - group9: bits 7-4 absent; lc3,wg3,cc3,t6
// - enable one passes source, zero blocks it
// - implemented bits read/write, reset to zero
// - unimplemented bits always read zero
// - source flags observed regardless of enables
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "pieb_defs.vh"

module pieb_bank #(
  parameter AW = 4,
  parameter DW = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register port
  input wire [AW-1:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata,
  // peripheral flag inputs
  input wire [7:0] flag_grp4,
  input wire [7:0] flag_grp5,
  input wire [7:0] flag_grp6,
  input wire [7:0] flag_grp7,
  input wire [7:0] flag_grp8,
  input wire [7:0] flag_grp9,
  // gated requests to priority and vectoring logic
  output wire [7:0] req_grp4,
  output wire [7:0] req_grp5,
  output wire [7:0] req_grp6,
  output wire [7:0] req_grp7,
  output wire [7:0] req_grp8,
  output wire [7:0] req_grp9,
  // summary interrupt
  output wire irq
);

  localparam NGRP = 6;
  localparam NSRC = NGRP * 8;

  // implemented masks, group 4 in the low byte
  localparam [NSRC-1:0] IMPL_ALL = {
    `PIEB_IMPL_G9, `PIEB_IMPL_G8, `PIEB_IMPL_G7,
    `PIEB_IMPL_G6, `PIEB_IMPL_G5, `PIEB_IMPL_G4
  };

  // enable register offsets, group 4 in the low field
  localparam [NGRP*AW-1:0] EN_OFS_ALL = {
    `PIEB_OFS_EN_G9, `PIEB_OFS_EN_G8, `PIEB_OFS_EN_G7,
    `PIEB_OFS_EN_G6, `PIEB_OFS_EN_G5, `PIEB_OFS_EN_G4
  };

  wire [NSRC-1:0] flag_all;
  wire [NSRC-1:0] en_all;
  wire [NSRC-1:0] next_req;
  reg [NSRC-1:0] req_all;
  wire [NGRP-1:0] en_wr;
  wire [NGRP-1:0] grp_pending;
  wire [NGRP-1:0] grp_new;
  reg [NGRP-1:0] evt_status;
  reg [NGRP-1:0] evt_mask;
  wire [NGRP-1:0] evt_clear;
  reg [DW-1:0] next_rdata;
  reg [5:0] active_cnt;
  reg [5:0] next_active_cnt;
  integer cnt_i;

  // flag packing, group 4 lowest
  assign flag_all[7:0] = flag_grp4;
  assign flag_all[15:8] = flag_grp5;
  assign flag_all[23:16] = flag_grp6;
  assign flag_all[31:24] = flag_grp7;
  assign flag_all[39:32] = flag_grp8;
  assign flag_all[47:40] = flag_grp9;

  // request unpacking
  assign req_grp4 = req_all[7:0];
  assign req_grp5 = req_all[15:8];
  assign req_grp6 = req_all[23:16];
  assign req_grp7 = req_all[31:24];
  assign req_grp8 = req_all[39:32];
  assign req_grp9 = req_all[47:40];

  // one enable register per group
  genvar g;
  generate
    for (g = 0; g < NGRP; g = g + 1) begin : grp
      assign en_wr[g] = reg_wr && (reg_addr == EN_OFS_ALL[g*AW +: AW]);
      pieb_enable_reg #(
        .WIDTH(8),
        .IMPL(IMPL_ALL[g*8 +: 8])
      ) u_en (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(en_wr[g]),
        .wr_data(reg_wdata[7:0]),
        .q(en_all[g*8 +: 8])
      );
      // new request appears in this group
      assign grp_new[g] = |(next_req[g*8 +: 8] & ~req_all[g*8 +: 8]);
      assign grp_pending[g] = |req_all[g*8 +: 8];
    end
  endgenerate

  // per-group views of the stored enables
  wire [7:0] en_g4 = en_all[7:0];
  wire [7:0] en_g5 = en_all[15:8];
  wire [7:0] en_g6 = en_all[23:16];
  wire [7:0] en_g7 = en_all[31:24];
  wire [7:0] en_g8 = en_all[39:32];
  wire [7:0] en_g9 = en_all[47:40];

  // named enable bits, one per interrupt source
  wire logic_cell1_irq_en;
  wire waveform_gen1_irq_en;
  wire num_osc1_irq_en;
  wire capcomp1_irq_en;
  wire timer2_irq_en;
  wire timer1_gate_irq_en;
  wire timer1_irq_en;
  wire i2c_port2_tx_irq_en;
  wire i2c_port2_rx_irq_en;
  wire dma_ch2_abort_irq_en;
  wire dma_ch2_overrun_irq_en;
  wire dma_ch2_dest_count_irq_en;
  wire dma_ch2_src_count_irq_en;
  wire comparator2_irq_en;
  wire ext_pin1_irq_en;
  wire timer3_gate_irq_en;
  wire timer3_irq_en;
  wire serial2_irq_en;
  wire serial2_framing_irq_en;
  wire serial2_tx_irq_en;
  wire serial2_rx_irq_en;
  wire i2c_port2_error_irq_en;
  wire i2c_port2_irq_en;
  wire ext_pin2_irq_en;
  wire logic_cell2_irq_en;
  wire waveform_gen2_irq_en;
  wire capcomp2_irq_en;
  wire timer4_irq_en;
  wire timer5_gate_irq_en;
  wire timer5_irq_en;
  wire logic_cell3_irq_en;
  wire waveform_gen3_irq_en;
  wire capcomp3_irq_en;
  wire timer6_irq_en;

  // group 4 fields
  assign logic_cell1_irq_en = en_g4[`PIEB_LOGIC_CELL1_IRQ_EN];
  assign waveform_gen1_irq_en = en_g4[`PIEB_WAVEFORM_GEN1_IRQ_EN];
  assign num_osc1_irq_en = en_g4[`PIEB_NUM_OSC1_IRQ_EN];
  assign capcomp1_irq_en = en_g4[`PIEB_CAPCOMP1_IRQ_EN];
  assign timer2_irq_en = en_g4[`PIEB_TIMER2_IRQ_EN];
  assign timer1_gate_irq_en = en_g4[`PIEB_TIMER1_GATE_IRQ_EN];
  assign timer1_irq_en = en_g4[`PIEB_TIMER1_IRQ_EN];
  // group 5 fields
  assign i2c_port2_tx_irq_en = en_g5[`PIEB_I2C_PORT2_TX_IRQ_EN];
  assign i2c_port2_rx_irq_en = en_g5[`PIEB_I2C_PORT2_RX_IRQ_EN];
  assign dma_ch2_abort_irq_en = en_g5[`PIEB_DMA_CH2_ABORT_IRQ_EN];
  assign dma_ch2_overrun_irq_en = en_g5[`PIEB_DMA_CH2_OVERRUN_IRQ_EN];
  assign dma_ch2_dest_count_irq_en = en_g5[`PIEB_DMA_CH2_DEST_COUNT_IRQ_EN];
  assign dma_ch2_src_count_irq_en = en_g5[`PIEB_DMA_CH2_SRC_COUNT_IRQ_EN];
  assign comparator2_irq_en = en_g5[`PIEB_COMPARATOR2_IRQ_EN];
  assign ext_pin1_irq_en = en_g5[`PIEB_EXT_PIN1_IRQ_EN];
  // group 6 fields
  assign timer3_gate_irq_en = en_g6[`PIEB_TIMER3_GATE_IRQ_EN];
  assign timer3_irq_en = en_g6[`PIEB_TIMER3_IRQ_EN];
  assign serial2_irq_en = en_g6[`PIEB_SERIAL2_IRQ_EN];
  assign serial2_framing_irq_en = en_g6[`PIEB_SERIAL2_FRAMING_IRQ_EN];
  assign serial2_tx_irq_en = en_g6[`PIEB_SERIAL2_TX_IRQ_EN];
  assign serial2_rx_irq_en = en_g6[`PIEB_SERIAL2_RX_IRQ_EN];
  assign i2c_port2_error_irq_en = en_g6[`PIEB_I2C_PORT2_ERROR_IRQ_EN];
  assign i2c_port2_irq_en = en_g6[`PIEB_I2C_PORT2_IRQ_EN];
  // group 7 fields
  assign ext_pin2_irq_en = en_g7[`PIEB_EXT_PIN2_IRQ_EN];
  assign logic_cell2_irq_en = en_g7[`PIEB_LOGIC_CELL2_IRQ_EN];
  assign waveform_gen2_irq_en = en_g7[`PIEB_WAVEFORM_GEN2_IRQ_EN];
  assign capcomp2_irq_en = en_g7[`PIEB_CAPCOMP2_IRQ_EN];
  assign timer4_irq_en = en_g7[`PIEB_TIMER4_IRQ_EN];
  // group 8 fields
  assign timer5_gate_irq_en = en_g8[`PIEB_TIMER5_GATE_IRQ_EN];
  assign timer5_irq_en = en_g8[`PIEB_TIMER5_IRQ_EN];
  // group 9 fields
  assign logic_cell3_irq_en = en_g9[`PIEB_LOGIC_CELL3_IRQ_EN];
  assign waveform_gen3_irq_en = en_g9[`PIEB_WAVEFORM_GEN3_IRQ_EN];
  assign capcomp3_irq_en = en_g9[`PIEB_CAPCOMP3_IRQ_EN];
  assign timer6_irq_en = en_g9[`PIEB_TIMER6_IRQ_EN];

  // read values rebuilt field by field; a position with no field
  // keeps the zero default, so it cannot read back a one
  reg [7:0] rd_g4;
  reg [7:0] rd_g5;
  reg [7:0] rd_g6;
  reg [7:0] rd_g7;
  reg [7:0] rd_g8;
  reg [7:0] rd_g9;

  always @* begin
    rd_g4 = 8'h00;
    rd_g4[`PIEB_LOGIC_CELL1_IRQ_EN] = logic_cell1_irq_en;
    rd_g4[`PIEB_WAVEFORM_GEN1_IRQ_EN] = waveform_gen1_irq_en;
    rd_g4[`PIEB_NUM_OSC1_IRQ_EN] = num_osc1_irq_en;
    rd_g4[`PIEB_CAPCOMP1_IRQ_EN] = capcomp1_irq_en;
    rd_g4[`PIEB_TIMER2_IRQ_EN] = timer2_irq_en;
    rd_g4[`PIEB_TIMER1_GATE_IRQ_EN] = timer1_gate_irq_en;
    rd_g4[`PIEB_TIMER1_IRQ_EN] = timer1_irq_en;
  end
  always @* begin
    rd_g5 = 8'h00;
    rd_g5[`PIEB_I2C_PORT2_TX_IRQ_EN] = i2c_port2_tx_irq_en;
    rd_g5[`PIEB_I2C_PORT2_RX_IRQ_EN] = i2c_port2_rx_irq_en;
    rd_g5[`PIEB_DMA_CH2_ABORT_IRQ_EN] = dma_ch2_abort_irq_en;
    rd_g5[`PIEB_DMA_CH2_OVERRUN_IRQ_EN] = dma_ch2_overrun_irq_en;
    rd_g5[`PIEB_DMA_CH2_DEST_COUNT_IRQ_EN] = dma_ch2_dest_count_irq_en;
    rd_g5[`PIEB_DMA_CH2_SRC_COUNT_IRQ_EN] = dma_ch2_src_count_irq_en;
    rd_g5[`PIEB_COMPARATOR2_IRQ_EN] = comparator2_irq_en;
    rd_g5[`PIEB_EXT_PIN1_IRQ_EN] = ext_pin1_irq_en;
  end
  always @* begin
    rd_g6 = 8'h00;
    rd_g6[`PIEB_TIMER3_GATE_IRQ_EN] = timer3_gate_irq_en;
    rd_g6[`PIEB_TIMER3_IRQ_EN] = timer3_irq_en;
    rd_g6[`PIEB_SERIAL2_IRQ_EN] = serial2_irq_en;
    rd_g6[`PIEB_SERIAL2_FRAMING_IRQ_EN] = serial2_framing_irq_en;
    rd_g6[`PIEB_SERIAL2_TX_IRQ_EN] = serial2_tx_irq_en;
    rd_g6[`PIEB_SERIAL2_RX_IRQ_EN] = serial2_rx_irq_en;
    rd_g6[`PIEB_I2C_PORT2_ERROR_IRQ_EN] = i2c_port2_error_irq_en;
    rd_g6[`PIEB_I2C_PORT2_IRQ_EN] = i2c_port2_irq_en;
  end
  always @* begin
    rd_g7 = 8'h00;
    rd_g7[`PIEB_EXT_PIN2_IRQ_EN] = ext_pin2_irq_en;
    rd_g7[`PIEB_LOGIC_CELL2_IRQ_EN] = logic_cell2_irq_en;
    rd_g7[`PIEB_WAVEFORM_GEN2_IRQ_EN] = waveform_gen2_irq_en;
    rd_g7[`PIEB_CAPCOMP2_IRQ_EN] = capcomp2_irq_en;
    rd_g7[`PIEB_TIMER4_IRQ_EN] = timer4_irq_en;
  end
  always @* begin
    rd_g8 = 8'h00;
    rd_g8[`PIEB_TIMER5_GATE_IRQ_EN] = timer5_gate_irq_en;
    rd_g8[`PIEB_TIMER5_IRQ_EN] = timer5_irq_en;
  end
  always @* begin
    rd_g9 = 8'h00;
    rd_g9[`PIEB_LOGIC_CELL3_IRQ_EN] = logic_cell3_irq_en;
    rd_g9[`PIEB_WAVEFORM_GEN3_IRQ_EN] = waveform_gen3_irq_en;
    rd_g9[`PIEB_CAPCOMP3_IRQ_EN] = capcomp3_irq_en;
    rd_g9[`PIEB_TIMER6_IRQ_EN] = timer6_irq_en;
  end

  // flag and enable both one, nothing else passes
  assign next_req = flag_all & en_all & IMPL_ALL;

  // requests leave from flip-flops; costs one cycle of latency
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_all <= {NSRC{1'b0}};
    end else begin
      req_all <= next_req;
    end
  end

  // number of requests currently forwarded
  always @* begin
    next_active_cnt = 6'h00;
    for (cnt_i = 0; cnt_i < NSRC; cnt_i = cnt_i + 1) begin
      next_active_cnt = next_active_cnt + {5'h00, next_req[cnt_i]};
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      active_cnt <= 6'h00;
    end else begin
      active_cnt <= next_active_cnt;
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  assign evt_clear = (reg_wr && reg_addr == `PIEB_OFS_EVT_STATUS) ?
    reg_wdata[NGRP-1:0] : {NGRP{1'b0}};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= {NGRP{1'b0}};
    end else begin
      evt_status <= (evt_status & ~evt_clear) | grp_new;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask <= {NGRP{1'b0}};
    end else if (reg_wr && reg_addr == `PIEB_OFS_EVT_MASK) begin
      evt_mask <= reg_wdata[NGRP-1:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

  // read mux; raw flags are shown whatever the enables hold
  always @* begin
    next_rdata = {DW{1'b0}};
    case (reg_addr)
      `PIEB_OFS_EN_G4: next_rdata[7:0] = rd_g4;
      `PIEB_OFS_EN_G5: next_rdata[7:0] = rd_g5;
      `PIEB_OFS_EN_G6: next_rdata[7:0] = rd_g6;
      `PIEB_OFS_EN_G7: next_rdata[7:0] = rd_g7;
      `PIEB_OFS_EN_G8: next_rdata[7:0] = rd_g8;
      `PIEB_OFS_EN_G9: next_rdata[7:0] = rd_g9;
      4'h6: next_rdata[7:0] = flag_all[7:0] & `PIEB_IMPL_G4;
      4'h7: next_rdata[7:0] = flag_all[15:8] & `PIEB_IMPL_G5;
      4'h8: next_rdata[7:0] = flag_all[23:16] & `PIEB_IMPL_G6;
      4'h9: next_rdata[7:0] = flag_all[31:24] & `PIEB_IMPL_G7;
      4'ha: next_rdata[7:0] = flag_all[39:32] & `PIEB_IMPL_G8;
      `PIEB_OFS_FLAG_G9: next_rdata[7:0] =
        flag_all[47:40] & `PIEB_IMPL_G9;
      `PIEB_OFS_EVT_STATUS: next_rdata[NGRP-1:0] = evt_status;
      `PIEB_OFS_EVT_MASK: next_rdata[NGRP-1:0] = evt_mask;
      `PIEB_OFS_PENDING: next_rdata[NGRP-1:0] = grp_pending;
      `PIEB_OFS_ACTIVE_CNT: next_rdata[5:0] = active_cnt;
      default: next_rdata = {DW{1'b0}};
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end

endmodule

// >>> rtl/pieb_defs.vh
// offsets, field positions, implemented masks and reset values
`ifndef PIEB_DEFS_VH
`define PIEB_DEFS_VH

// register word offsets on the plain register port
`define PIEB_OFS_EN_G4 4'h0
`define PIEB_OFS_EN_G5 4'h1
`define PIEB_OFS_EN_G6 4'h2
`define PIEB_OFS_EN_G7 4'h3
`define PIEB_OFS_EN_G8 4'h4
`define PIEB_OFS_EN_G9 4'h5
`define PIEB_OFS_FLAG_G4 4'h6
`define PIEB_OFS_FLAG_G9 4'hb
`define PIEB_OFS_EVT_STATUS 4'hc
`define PIEB_OFS_EVT_MASK 4'hd
`define PIEB_OFS_PENDING 4'he
`define PIEB_OFS_ACTIVE_CNT 4'hf

// reset value of every enable register
`define PIEB_EN_RESET 8'h00

// implemented bit masks per enable register
`define PIEB_IMPL_G4 8'hef
`define PIEB_IMPL_G5 8'hff
`define PIEB_IMPL_G6 8'hff
`define PIEB_IMPL_G7 8'h3b
`define PIEB_IMPL_G8 8'hc0
`define PIEB_IMPL_G9 8'h0f

// group 4 bit positions
`define PIEB_LOGIC_CELL1_IRQ_EN 7
`define PIEB_WAVEFORM_GEN1_IRQ_EN 6
`define PIEB_NUM_OSC1_IRQ_EN 5
`define PIEB_CAPCOMP1_IRQ_EN 3
`define PIEB_TIMER2_IRQ_EN 2
`define PIEB_TIMER1_GATE_IRQ_EN 1
`define PIEB_TIMER1_IRQ_EN 0

// group 5 bit positions
`define PIEB_I2C_PORT2_TX_IRQ_EN 7
`define PIEB_I2C_PORT2_RX_IRQ_EN 6
`define PIEB_DMA_CH2_ABORT_IRQ_EN 5
`define PIEB_DMA_CH2_OVERRUN_IRQ_EN 4
`define PIEB_DMA_CH2_DEST_COUNT_IRQ_EN 3
`define PIEB_DMA_CH2_SRC_COUNT_IRQ_EN 2
`define PIEB_COMPARATOR2_IRQ_EN 1
`define PIEB_EXT_PIN1_IRQ_EN 0

// group 6 bit positions
`define PIEB_TIMER3_GATE_IRQ_EN 7
`define PIEB_TIMER3_IRQ_EN 6
`define PIEB_SERIAL2_IRQ_EN 5
`define PIEB_SERIAL2_FRAMING_IRQ_EN 4
`define PIEB_SERIAL2_TX_IRQ_EN 3
`define PIEB_SERIAL2_RX_IRQ_EN 2
`define PIEB_I2C_PORT2_ERROR_IRQ_EN 1
`define PIEB_I2C_PORT2_IRQ_EN 0

// group 7 bit positions
`define PIEB_EXT_PIN2_IRQ_EN 5
`define PIEB_LOGIC_CELL2_IRQ_EN 4
`define PIEB_WAVEFORM_GEN2_IRQ_EN 3
`define PIEB_CAPCOMP2_IRQ_EN 1
`define PIEB_TIMER4_IRQ_EN 0

// group 8 bit positions
`define PIEB_TIMER5_GATE_IRQ_EN 7
`define PIEB_TIMER5_IRQ_EN 6

// group 9 bit positions
`define PIEB_LOGIC_CELL3_IRQ_EN 3
`define PIEB_WAVEFORM_GEN3_IRQ_EN 2
`define PIEB_CAPCOMP3_IRQ_EN 1
`define PIEB_TIMER6_IRQ_EN 0

`endif

// >>> rtl/pieb_enable_reg.v
// one enable register with fixed-zero unimplemented positions
`timescale 1ns/1ps
`include "pieb_defs.vh"

module pieb_enable_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] IMPL = {WIDTH{1'b1}}
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // write side
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  // stored value
  output reg [WIDTH-1:0] q
);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= `PIEB_EN_RESET;
    end else if (wr_en) begin
      // unimplemented positions never store, so they read back zero
      q <= wr_data & IMPL;
    end
  end

endmodule

// >>> tb/pieb_monitor.sv
// port assertions for the enable bank
`timescale 1ns/1ps
module pieb_monitor #(
  parameter AW = 4,
  parameter DW = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // read side of the register port
  input wire reg_rd,
  input wire [AW-1:0] reg_addr,
  input wire [DW-1:0] reg_rdata,
  // flags
  input wire [7:0] flag_grp5,
  input wire [7:0] flag_grp6,
  // requests
  input wire [7:0] req_grp4,
  input wire [7:0] req_grp5,
  input wire [7:0] req_grp6,
  input wire [7:0] req_grp7,
  input wire [7:0] req_grp8,
  input wire [7:0] req_grp9,
  // summary interrupt
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_g4_no_req: assert property (req_grp4[4] == 1'h0)
    else $error("group4 absent bit requested");
  a_g7_no_req: assert property ((req_grp7 & 8'hc4) == 8'h00)
    else $error("group7 absent bit requested");
  a_g8_no_req: assert property ((req_grp8 & 8'h3f) == 8'h00)
    else $error("group8 absent bit requested");
  a_g9_no_req: assert property ((req_grp9 & 8'hf0) == 8'h00)
    else $error("group9 absent bit requested");
  a_req_flag_g5: assert property (
    (req_grp5 & ~$past(flag_grp5)) == 8'h00)
    else $error("group5 request without flag");
  a_req_flag_g6: assert property (
    (req_grp6 & ~$past(flag_grp6)) == 8'h00)
    else $error("group6 request without flag");
  a_rd_g7_zero: assert property (
    reg_rd && reg_addr == 4'h3 |=> (reg_rdata & 8'hc4) == 8'h00)
    else $error("group7 absent bit read as one");
  a_rd_g9_zero: assert property (
    reg_rd && reg_addr == 4'h5 |=> (reg_rdata & 8'hf0) == 8'h00)
    else $error("group9 absent bit read as one");
  c_irq: cover property (irq);
  c_req5: cover property (|req_grp5);
  c_pend_rd: cover property (reg_rd && reg_addr == 4'he);
endmodule
bind pieb_bank pieb_monitor #(.AW(AW), .DW(DW)) mon_u (
  .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .flag_grp5(flag_grp5), .flag_grp6(flag_grp6),
  .req_grp4(req_grp4), .req_grp5(req_grp5), .req_grp6(req_grp6),
  .req_grp7(req_grp7), .req_grp8(req_grp8), .req_grp9(req_grp9), .irq(irq));

// >>> tb/pieb_src_model.sv
// peripheral sources: sticky flags set by events
`timescale 1ns/1ps
module pieb_src_model (
  input wire mclk,
  input wire rst_n,
  input wire [47:0] evt,
  input wire [47:0] clr,
  output reg [47:0] flags
);
  // set wins over clear so an event in the clearing cycle is kept
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      flags <= 48'h0;
    else
      flags <= (flags & ~clr) | evt;
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the enable bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  reg mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00, d;
  reg [47:0] evt = 48'h0, clr = 48'h0;
  reg [63:0] r;
  reg [7:0] en [0:5];
  wire [47:0] flags, req;
  wire [7:0] reg_rdata;
  wire irq;
  integer errors = 0, n_tests = 0, cyc = 0, seed = 32'h6994c192, g, k;
  always #12.5 mclk = ~mclk;
  pieb_src_model src_u (.mclk(mclk), .rst_n(rst_n), .evt(evt), .clr(clr),
    .flags(flags));
  pieb_bank dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flag_grp4(flags[7:0]), .flag_grp5(flags[15:8]),
    .flag_grp6(flags[23:16]), .flag_grp7(flags[31:24]),
    .flag_grp8(flags[39:32]), .flag_grp9(flags[47:40]),
    .req_grp4(req[7:0]), .req_grp5(req[15:8]), .req_grp6(req[23:16]),
    .req_grp7(req[31:24]), .req_grp8(req[39:32]), .req_grp9(req[47:40]),
    .irq(irq));
  function [7:0] impl(input integer g);
    case (g)
      0: impl = 8'hef;
      3: impl = 8'h3b;
      4: impl = 8'hc0;
      5: impl = 8'h0f;
      default: impl = 8'hff;
    endcase
  endfunction
  task wr(input [3:0] a, input [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task chk_rd(input [3:0] a, input [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task do_reset;
    rst_n <= 1'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
  endtask
  task clear_flags;
    clr <= 48'hffffffffffff;
    @(posedge mclk);
    clr <= 48'h0;
  endtask
  task pulse(input [47:0] v);
    evt <= v;
    @(posedge mclk);
    evt <= 48'h0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    do_reset;
    for (k = 0; k < 2; k++) begin
      for (g = 0; g < 6; g++) chk_rd(g[3:0], 8'h00);
      // all ones: only the implemented positions may stick
      for (g = 0; g < 6; g++) begin
        wr(g[3:0], 8'hff);
        chk_rd(g[3:0], impl(g));
      end
      for (g = 0; g < 6; g++) repeat (4) begin
        r = {$random(seed), $random(seed)};
        wr(g[3:0], r[7:0]);
        chk_rd(g[3:0], r[7:0] & impl(g));
      end
      // second pass resets with enables set, in mid-run
      do_reset;
    end
    $display("test registers done");
    for (k = 0; k < 20; k++) begin
      // flags cleared before enabling, so no stale request
      clear_flags;
      for (g = 0; g < 6; g++) begin
        r = {$random(seed), $random(seed)};
        en[g] = r[7:0];
        wr(g[3:0], en[g]);
      end
      r = {$random(seed), $random(seed)};
      pulse(r[47:0]);
      for (g = 0; g < 6; g++) begin
        d = flags[8*g +: 8] & impl(g);
        `CHK(req[8*g +: 8], d & en[g])
        chk_rd(4'h6 + g[3:0], d);
      end
    end
    $display("test gating done");
    clear_flags;
    wr(4'h0, 8'h01);
    wr(4'hc, 8'h3f);
    wr(4'hd, 8'h3f);
    pulse(48'h1);
    `CHK(irq, 1'h1)
    chk_rd(4'he, 8'h01);
    chk_rd(4'hf, 8'h01);
    chk_rd(4'hc, 8'h01);
    chk_rd(4'hd, 8'h3f);
    wr(4'hd, 8'h00);
    `CHK(irq, 1'h0)
    wr(4'hd, 8'h01);
    `CHK(irq, 1'h1)
    clear_flags;
    wr(4'hc, 8'h01);
    `CHK(irq, 1'h0)
    chk_rd(4'hc, 8'h00);
    $display("test interrupt done");
    end_of_test;
  end
endmodule
